/* File: verilog/count_incr_bit_branch_exec.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Opcode 84H divides accumulator by B, finishing in four machine cycles.
// - Divide by non-zero leaves carry and signed_excess_flag cleared.
// - Quotient goes to accumulator, remainder goes to B.
// - Zero divisor sets signed_excess_flag, clears carry; A and B undefined.
// - count_down_branch decrements with wrap, branches if non-zero, flags untouched.
// - count_down_branch target is next instruction address plus signed displacement.
// - Port read-modify-write takes the original value from the output latch.
// - Register count_down_branch is 11011rrr, two bytes, two cycles.
// - Direct count_down_branch is D5H, three bytes, two cycles.
// - add_one_instr increments with wrap and alters no flags.
// - add_one_instr forms take one cycle; direct is two bytes, others one.
// - Opcode A3H increments pointer_reg16 modulo 2^16 in two cycles.
// - branch_if_bit_set, 20H, three bytes, two cycles, branches on one.
// - branch_test_clear, 10H, clears bit and branches only when it is one.
// - Bit-branch target is next instruction address plus signed third byte.
module count_incr_bit_branch_exec (
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire exec_pkg::exec_req_t req,
   output logic                     busy,
   output exec_pkg::exec_resp_t     resp
);

   exec_pkg::exec_state_t s_q;
   exec_pkg::exec_state_t s_d;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0]  src;
      logic [15:0] npc;
      logic [15:0] len;
      logic [2:0]  cyc;
      logic [7:0]  rel;
      exec_pkg::kind_t kind;
      src  = req.is_port ? req.latch : req.operand;
      npc  = req.pc;
      len  = exec_pkg::LEN_ONE;
      cyc  = exec_pkg::CYC_ONE;
      rel  = req.byte2;
      kind = exec_pkg::K_NONE;
      s_d  = s_q;
      s_d.resp.done = 1'b0;
      if (req.opcode == exec_pkg::OP_DIVIDE) begin
         kind = exec_pkg::K_DIV;
         cyc  = exec_pkg::CYC_DIVIDE;
      end else if ((req.opcode & exec_pkg::OP_REG_MASK) == exec_pkg::OP_COUNT_DOWN_BRANCH_REG) begin
         kind = exec_pkg::K_COUNT_DOWN_BRANCH;
         cyc  = exec_pkg::CYC_TWO;
         len  = exec_pkg::LEN_TWO;
         rel  = req.byte1;
      end else if (req.opcode == exec_pkg::OP_COUNT_DOWN_BRANCH_DIR) begin
         kind = exec_pkg::K_COUNT_DOWN_BRANCH;
         cyc  = exec_pkg::CYC_TWO;
         len  = exec_pkg::LEN_THREE;
      end else if (req.opcode == exec_pkg::OP_INC_ACC) begin
         kind = exec_pkg::K_INC;
         src  = req.acc;
      end else if (req.opcode == exec_pkg::OP_INC_DIR) begin
         kind = exec_pkg::K_INC;
         len  = exec_pkg::LEN_TWO;
      end else if ((req.opcode & exec_pkg::OP_IND_MASK) == exec_pkg::OP_INC_IND ||
                   (req.opcode & exec_pkg::OP_REG_MASK) == exec_pkg::OP_INC_REG) begin
         kind = exec_pkg::K_INC;
      end else if (req.opcode == exec_pkg::OP_INC_PTR) begin
         kind = exec_pkg::K_PTR;
         cyc  = exec_pkg::CYC_TWO;
      end else if (req.opcode == exec_pkg::OP_BIT_BRANCH) begin
         kind = exec_pkg::K_JB;
         cyc  = exec_pkg::CYC_TWO;
         len  = exec_pkg::LEN_THREE;
      end else if (req.opcode == exec_pkg::OP_BIT_CLEAR) begin
         kind = exec_pkg::K_JBC;
         cyc  = exec_pkg::CYC_TWO;
         len  = exec_pkg::LEN_THREE;
      end
      npc = req.pc + len;
      case (s_q.fsm)
         exec_pkg::ST_IDLE: begin
            if (req.valid && kind != exec_pkg::K_NONE) begin
               s_d.fsm  = exec_pkg::ST_RUN;
               s_d.kind = kind;
               s_d.cnt  = cyc;
               s_d.rel  = rel;
               s_d.resp = '0;
               s_d.resp.next_pc = npc;
               // Target is always formed; branch says whether to take it
               s_d.resp.target  = npc + {{8{rel[7]}}, rel};
               case (kind)
                  exec_pkg::K_DIV: begin
                     s_d.resp.acc_we = 1'b1;
                     s_d.resp.b_we   = 1'b1;
                     s_d.resp.cy_we  = 1'b1;
                     s_d.resp.ov_we  = 1'b1;
                     s_d.resp.cy     = 1'b0;
                     if (req.b == exec_pkg::BYTE_ZERO) begin
                        s_d.resp.ov  = 1'b1;
                        s_d.resp.acc = exec_pkg::DIV_ZERO_FILL;
                        s_d.resp.b   = req.acc;
                     end else begin
                        s_d.resp.ov  = 1'b0;
                        s_d.resp.acc = req.acc / req.b;
                        s_d.resp.b   = req.acc % req.b;
                     end
                  end
                  exec_pkg::K_COUNT_DOWN_BRANCH: begin
                     s_d.resp.opnd_we = 1'b1;
                     s_d.resp.opnd    = src - exec_pkg::BYTE_ONE;
                     s_d.resp.branch  = (src != exec_pkg::BYTE_ONE);
                  end
                  exec_pkg::K_INC: begin
                     s_d.resp.opnd_we = 1'b1;
                     s_d.resp.opnd    = src + exec_pkg::BYTE_ONE;
                  end
                  exec_pkg::K_PTR: begin
                     s_d.resp.pointer_reg16_we = 1'b1;
                     s_d.resp.pointer_reg16    = req.pointer_reg16 + exec_pkg::LEN_ONE;
                  end
                  exec_pkg::K_JB: begin
                     s_d.resp.branch  = req.pin_bit;
                  end
                  exec_pkg::K_JBC: begin
                     s_d.resp.branch  = req.is_port ? req.latch_bit : req.pin_bit;
                     s_d.resp.bit_clr = s_d.resp.branch;
                  end
                  default: begin
                     s_d.resp.branch  = 1'b0;
                  end
               endcase
            end
         end
         exec_pkg::ST_RUN: begin
            if (s_q.cnt == exec_pkg::CYC_ONE) begin
               s_d.fsm       = exec_pkg::ST_IDLE;
               s_d.resp.done = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - exec_pkg::CYC_ONE;
            end
         end
         default: begin
            s_d.fsm = exec_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   logic busy_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (s_d.fsm == exec_pkg::ST_RUN);
      end
   end

   assign resp = s_q.resp;
   assign busy = busy_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic take;
   assign take = req.valid && s_q.fsm == exec_pkg::ST_IDLE;

   property p_div_time;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_DIVIDE |-> ##1 !resp.done [*4] ##1 resp.done;
   endproperty
   a_div_time: assert property (p_div_time) else $error("divide not done in four cycles");

   property p_div_ok;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_DIVIDE && req.b != exec_pkg::BYTE_ZERO
      |-> ##5 resp.done && !resp.cy && !resp.ov && resp.cy_we && resp.ov_we;
   endproperty
   a_div_ok: assert property (p_div_ok) else $error("divide flags not cleared");

   property p_div_val;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_DIVIDE && req.b != exec_pkg::BYTE_ZERO
      |-> ##5 resp.acc == $past(req.acc, 5) / $past(req.b, 5)
          && resp.b == $past(req.acc, 5) % $past(req.b, 5);
   endproperty
   a_div_val: assert property (p_div_val) else $error("divide result wrong");

   property p_div_zero;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_DIVIDE && req.b == exec_pkg::BYTE_ZERO
      |-> ##5 resp.done && resp.ov && !resp.cy;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divisor flags wrong");

   property p_count_down_branch;
      @(posedge clock) disable iff (!arst_n)
      take && ((req.opcode & exec_pkg::OP_REG_MASK) == exec_pkg::OP_COUNT_DOWN_BRANCH_REG
               || req.opcode == exec_pkg::OP_COUNT_DOWN_BRANCH_DIR)
      |-> ##1 !resp.done [*2] ##1 resp.done && !resp.cy_we && !resp.ov_we
          && resp.branch == (resp.opnd != exec_pkg::BYTE_ZERO);
   endproperty
   a_count_down_branch: assert property (p_count_down_branch) else $error("count_down_branch wrong");

   property p_target;
      @(posedge clock) disable iff (!arst_n)
      resp.done && (s_q.kind == exec_pkg::K_COUNT_DOWN_BRANCH || s_q.kind == exec_pkg::K_JB
                    || s_q.kind == exec_pkg::K_JBC)
      |-> resp.target == resp.next_pc + {{8{s_q.rel[7]}}, s_q.rel};
   endproperty
   a_target: assert property (p_target) else $error("branch target wrong");

   property p_latch;
      @(posedge clock) disable iff (!arst_n)
      take && req.is_port && req.opcode == exec_pkg::OP_INC_DIR
      |-> ##2 resp.done && resp.opnd == $past(req.latch, 2) + exec_pkg::BYTE_ONE;
   endproperty
   a_latch: assert property (p_latch) else $error("port latch not used");

   property p_count_down_branch_len;
      @(posedge clock) disable iff (!arst_n)
      take && (req.opcode & exec_pkg::OP_REG_MASK) == exec_pkg::OP_COUNT_DOWN_BRANCH_REG
      |-> ##2 resp.next_pc == $past(req.pc, 2) + exec_pkg::LEN_TWO;
   endproperty
   a_count_down_branch_len: assert property (p_count_down_branch_len) else $error("register form length wrong");

   property p_inc;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_INC_ACC
      |-> ##2 resp.done && !resp.cy_we && !resp.ov_we
          && resp.opnd == $past(req.acc, 2) + exec_pkg::BYTE_ONE;
   endproperty
   a_inc: assert property (p_inc) else $error("accumulator increment wrong");

   property p_ptr;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_INC_PTR
      |-> ##3 resp.done && resp.pointer_reg16_we && resp.pointer_reg16 == $past(req.pointer_reg16, 3) + exec_pkg::LEN_ONE;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer increment wrong");

   property p_jbc;
      @(posedge clock) disable iff (!arst_n)
      take && req.opcode == exec_pkg::OP_BIT_CLEAR && !req.is_port
      |-> ##3 resp.done && resp.bit_clr == $past(req.pin_bit, 3)
          && resp.branch == $past(req.pin_bit, 3);
   endproperty
   a_jbc: assert property (p_jbc) else $error("test-and-clear wrong");

endmodule

`default_nettype wire

/* File: common/exec_pkg.sv */
package exec_pkg;

   // ---------------------------------------------------------------
   // Opcodes and opcode masks
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_DIVIDE      = 8'h84;
   localparam logic [7:0] OP_COUNT_DOWN_BRANCH_DIR    = 8'hD5;
   localparam logic [7:0] OP_COUNT_DOWN_BRANCH_REG    = 8'hD8;
   localparam logic [7:0] OP_REG_MASK    = 8'hF8;
   localparam logic [7:0] OP_INC_ACC     = 8'h04;
   localparam logic [7:0] OP_INC_DIR     = 8'h05;
   localparam logic [7:0] OP_INC_IND     = 8'h06;
   localparam logic [7:0] OP_IND_MASK    = 8'hFE;
   localparam logic [7:0] OP_INC_REG     = 8'h08;
   localparam logic [7:0] OP_INC_PTR     = 8'hA3;
   localparam logic [7:0] OP_BIT_BRANCH  = 8'h20;
   localparam logic [7:0] OP_BIT_CLEAR   = 8'h10;

   // ---------------------------------------------------------------
   // Machine cycles and byte counts
   // ---------------------------------------------------------------
   localparam logic [2:0]  CYC_DIVIDE    = 3'h4;
   localparam logic [2:0]  CYC_TWO       = 3'h2;
   localparam logic [2:0]  CYC_ONE       = 3'h1;
   localparam logic [15:0] LEN_ONE       = 16'h0001;
   localparam logic [15:0] LEN_TWO       = 16'h0002;
   localparam logic [15:0] LEN_THREE     = 16'h0003;
   localparam logic [7:0]  BYTE_ONE      = 8'h01;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [7:0]  DIV_ZERO_FILL = 8'hFF;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } fsm_t;

   typedef enum logic [2:0] {
      K_NONE, K_DIV, K_COUNT_DOWN_BRANCH, K_INC, K_PTR, K_JB, K_JBC
   } kind_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [7:0]  byte1;
      logic [7:0]  byte2;
      logic [15:0] pc;
      logic [7:0]  acc;
      logic [7:0]  b;
      logic [7:0]  operand;
      logic [7:0]  latch;
      logic        is_port;
      logic        pin_bit;
      logic        latch_bit;
      logic [15:0] pointer_reg16;
   } exec_req_t;

   typedef struct packed {
      logic        done;
      logic        acc_we;
      logic [7:0]  acc;
      logic        b_we;
      logic [7:0]  b;
      logic        opnd_we;
      logic [7:0]  opnd;
      logic        bit_clr;
      logic        pointer_reg16_we;
      logic [15:0] pointer_reg16;
      logic        branch;
      logic [15:0] target;
      logic [15:0] next_pc;
      logic        cy_we;
      logic        cy;
      logic        ov_we;
      logic        ov;
   } exec_resp_t;

   typedef struct packed {
      fsm_t       fsm;
      kind_t      kind;
      logic [2:0] cnt;
      logic [7:0] rel;
      exec_resp_t resp;
   } exec_state_t;

endpackage

/* File: dv/count_incr_bit_branch_exec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module count_incr_bit_branch_exec_tb_top;

   typedef struct {
      exec_pkg::kind_t k;
      logic [7:0]      op;
      logic [7:0]      rel;
      logic [15:0]     src;
      logic [2:0]      flg;
      logic [15:0]     pc;
      logic [2:0]      cyc;
      logic [1:0]      len;
      logic [15:0]     res;
      logic            br;
   } row_t;

   logic                 clock;
   logic                 arst_n;
   exec_pkg::exec_req_t  req;
   logic                 busy;
   exec_pkg::exec_resp_t resp;
   int                   n_fail;
   int                   total_checks;
   int                   cyc;
   logic [15:0]          tgt;
   row_t                 rows[$];

   count_incr_bit_branch_exec uut (
      .clock  (clock),
      .arst_n (arst_n),
      .req    (req),
      .busy   (busy),
      .resp   (resp)
   );

   always #4 clock = ~clock;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The unused displacement byte, and operand for opcode 04H, carry the inverse so a wrong source shows up
   task automatic load(input row_t r);
      logic reg_form;
      reg_form      = (r.op & exec_pkg::OP_REG_MASK) == exec_pkg::OP_COUNT_DOWN_BRANCH_REG;
      req           = '0;
      req.valid     = 1'h1;
      req.opcode    = r.op;
      req.byte1     = reg_form ? r.rel : ~r.rel;
      req.byte2     = reg_form ? ~r.rel : r.rel;
      req.pc        = r.pc;
      req.acc       = r.src[15:8];
      req.b         = r.src[7:0];
      req.operand   = (r.op == exec_pkg::OP_INC_ACC) ? ~r.src[15:8] : r.src[15:8];
      req.latch     = r.src[7:0];
      req.is_port   = r.flg[2];
      req.pin_bit   = r.flg[1];
      req.latch_bit = r.flg[0];
      req.pointer_reg16      = r.src;
   endtask

   task automatic run(input row_t r);
      load(r);
      @(posedge clock);
      #1;
      req.valid = 1'h0;
      cyc = 0;
      do begin
         @(posedge clock);
         #1;
         cyc++;
      end while (resp.done !== 1'h1 && cyc < 10);
      if (resp.done !== 1'h1) begin
         n_fail++;
         $display("[ERR] done expected 1 seen %b", resp.done);
         wrap_up();
      end
   endtask

   task automatic check_row(input row_t r);
      tgt = r.pc + 16'(r.len) + {{8{r.rel[7]}}, r.rel};
      chk("cycles", cyc, 32'(r.cyc));
      chk("next_pc", resp.next_pc, 16'(r.pc + 16'(r.len)));
      chk("busy", busy, 1'h0);
      chk("cy_we", resp.cy_we, r.k == exec_pkg::K_DIV);
      chk("ov_we", resp.ov_we, r.k == exec_pkg::K_DIV);
      case (r.k)
         exec_pkg::K_DIV: begin
            chk("acc_we", resp.acc_we, 1'h1);
            chk("b_we", resp.b_we, 1'h1);
            chk("cy", resp.cy, 1'h0);
            chk("ov", resp.ov, r.src[7:0] == 8'h00);
            if (r.src[7:0] != 8'h00) begin
               chk("quotient", resp.acc, r.res[15:8]);
               chk("remainder", resp.b, r.res[7:0]);
            end
         end
         exec_pkg::K_PTR: begin
            chk("pointer_reg16_we", resp.pointer_reg16_we, 1'h1);
            chk("pointer_reg16", resp.pointer_reg16, r.res);
         end
         exec_pkg::K_INC, exec_pkg::K_COUNT_DOWN_BRANCH: begin
            chk("opnd_we", resp.opnd_we, 1'h1);
            chk("opnd", resp.opnd, r.res[7:0]);
         end
         default: begin
            chk("bit_clr", resp.bit_clr, r.res[0]);
            chk("opnd_we", resp.opnd_we, 1'h0);
         end
      endcase
      if (r.k == exec_pkg::K_COUNT_DOWN_BRANCH || r.k == exec_pkg::K_JB || r.k == exec_pkg::K_JBC) begin
         chk("branch", resp.branch, r.br);
         chk("target", resp.target, tgt);
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clock        = 1'h0;
      arst_n       = 1'h0;
      req          = '0;
      n_fail       = 0;
      total_checks = 0;
      rows = '{
         '{exec_pkg::K_DIV,8'h84,8'h00,16'hFB12,3'h0,16'h1000,3'h4,2'h1,16'h0D11,1'h0},
         '{exec_pkg::K_DIV,8'h84,8'h00,16'h1000,3'h0,16'h1000,3'h4,2'h1,16'h0000,1'h0},
         '{exec_pkg::K_DIV,8'h84,8'h00,16'hFF01,3'h0,16'h1000,3'h4,2'h1,16'hFF00,1'h0},
         '{exec_pkg::K_COUNT_DOWN_BRANCH,8'hDB,8'h10,16'h0155,3'h0,16'h1000,3'h2,2'h2,16'h0000,1'h0},
         '{exec_pkg::K_COUNT_DOWN_BRANCH,8'hDF,8'h80,16'h0055,3'h0,16'h1000,3'h2,2'h2,16'h00FF,1'h1},
         '{exec_pkg::K_COUNT_DOWN_BRANCH,8'hD5,8'h05,16'h7033,3'h0,16'h1000,3'h2,2'h3,16'h006F,1'h1},
         '{exec_pkg::K_COUNT_DOWN_BRANCH,8'hD5,8'hFB,16'h7001,3'h4,16'h1000,3'h2,2'h3,16'h0000,1'h0},
         '{exec_pkg::K_INC,8'h04,8'h00,16'hFF00,3'h0,16'h1000,3'h1,2'h1,16'h0000,1'h0},
         '{exec_pkg::K_INC,8'h0D,8'h00,16'h7E00,3'h0,16'h1000,3'h1,2'h1,16'h007F,1'h0},
         '{exec_pkg::K_INC,8'h05,8'h00,16'h7F40,3'h4,16'h1000,3'h1,2'h2,16'h0041,1'h0},
         '{exec_pkg::K_INC,8'h06,8'h00,16'hFF00,3'h0,16'h1000,3'h1,2'h1,16'h0000,1'h0},
         '{exec_pkg::K_INC,8'h07,8'h00,16'h4000,3'h0,16'h1000,3'h1,2'h1,16'h0041,1'h0},
         '{exec_pkg::K_PTR,8'hA3,8'h00,16'h12FE,3'h0,16'h1000,3'h2,2'h1,16'h12FF,1'h0},
         '{exec_pkg::K_PTR,8'hA3,8'h00,16'h12FF,3'h0,16'h1000,3'h2,2'h1,16'h1300,1'h0},
         '{exec_pkg::K_PTR,8'hA3,8'h00,16'hFFFF,3'h0,16'h1000,3'h2,2'h1,16'h0000,1'h0},
         '{exec_pkg::K_JB,8'h20,8'hFE,16'h0000,3'h2,16'hFFFE,3'h2,2'h3,16'h0000,1'h1},
         '{exec_pkg::K_JB,8'h20,8'h10,16'h0000,3'h1,16'h1000,3'h2,2'h3,16'h0000,1'h0},
         '{exec_pkg::K_JB,8'h20,8'h10,16'h0000,3'h6,16'h1000,3'h2,2'h3,16'h0000,1'h1},
         '{exec_pkg::K_JBC,8'h10,8'h7F,16'h0000,3'h5,16'h1000,3'h2,2'h3,16'h0001,1'h1},
         '{exec_pkg::K_JBC,8'h10,8'h7F,16'h0000,3'h2,16'h1000,3'h2,2'h3,16'h0001,1'h1},
         '{exec_pkg::K_JBC,8'h10,8'h80,16'h0000,3'h6,16'h1000,3'h2,2'h3,16'h0000,1'h0}
      };
      repeat (20) @(posedge clock);
      #1;
      chk("reset resp", resp === '0, 1'h1);
      chk("reset busy", busy, 1'h0);
      arst_n = 1'h1;
      foreach (rows[i]) begin
         run(rows[i]);
         check_row(rows[i]);
      end
      // Second request held while busy, refused on the last busy edge, taken next
      load(rows[0]);
      for (int i = 1; i <= 7; i++) begin
         @(posedge clock);
         #1;
         if (i == 1) load(rows[7]);
         if (i == 6) req.valid = 1'h0;
         chk("done", resp.done, i == 5 || i == 7);
         chk("busy", busy, i <= 4 || i == 6);
         if (i == 5) chk("quotient", resp.acc, 8'h0D);
         if (i == 7) chk("opnd", resp.opnd, 8'h00);
      end
      // Opcode outside this group is ignored
      req        = '0;
      req.valid  = 1'h1;
      req.opcode = 8'hA5;
      repeat (6) begin
         @(posedge clock);
         #1;
         req.valid = 1'h0;
         chk("ignored done", resp.done, 1'h0);
         chk("ignored busy", busy, 1'h0);
      end
      // Reset in the middle of a divide
      load(rows[0]);
      @(posedge clock);
      #1;
      req.valid = 1'h0;
      @(posedge clock);
      #1;
      arst_n = 1'h0;
      #1;
      chk("mid reset resp", resp === '0, 1'h1);
      chk("mid reset busy", busy, 1'h0);
      @(posedge clock);
      #1;
      arst_n = 1'h1;
      run(rows[9]);
      check_row(rows[9]);
      wrap_up();
   end

endmodule

`default_nettype wire
